// File: bench/msf_core_sva.sv
// Checker on the core ports: fetch word, sequencing and density rails.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/10ps
module msf_core_sva
(
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        sleep_mode,
    input wire logic [2:0]  out_select,
    input wire logic        command_mode,
    input wire logic        measure_request_cmd,
    input wire logic        fetch_done,
    input wire logic [31:0] fetch_data,
    input wire logic        fetch_valid,
    input wire logic        ready_pin,
    input wire logic        cap_density_out,
    input wire logic        temp_density_out,
    input wire logic        powered_down,
    input wire logic        conv_temp,
    input wire logic        conv_cap,
    input wire logic        diag_active,
    input wire logic        req_ack
);
    // ****************************************************************
    // Port properties
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    pad_bits_a:
        assert property (fetch_valid |-> fetch_data[1:0] == 2'h0)
        else $error("fetch word low bits not zero");
    diag_pair_a:
        assert property (fetch_valid && fetch_data[29:16] == 14'h3fff
            |-> fetch_data[15:2] == msf_pkg::DIAG_CODE)
        else $error("diagnostic code in one field only");
    cmd_status_a:
        assert property (fetch_valid && command_mode && $past(command_mode, 3)
            |-> fetch_data[31:30] == msf_pkg::STAT_CMD)
        else $error("command mode status missing");
    word_holds_a:
        assert property (fetch_valid && !fetch_done
            |=> fetch_valid && $stable(fetch_data))
        else $error("fetch word dropped before taken");
    temp_then_cap_a:
        assert property ($fell(conv_temp) |-> conv_cap)
        else $error("capacitance did not follow temperature");
    ready_after_cycle_a:
        assert property ($fell(conv_cap) && !ready_pin |-> ##[1:40] ready_pin)
        else $error("ready not raised after cycle");
    sleep_no_density_a:
        assert property (sleep_mode && $past(sleep_mode)
            |-> !cap_density_out && !temp_density_out)
        else $error("density output active in sleep mode");
    density_rail_a:
        assert property ((diag_active && !sleep_mode
            && out_select == msf_pkg::OSEL_PDM_CT) [*3]
            |-> cap_density_out && temp_density_out)
        else $error("density outputs not railed on diagnostic");
    no_ack_cont_a:
        assert property (!sleep_mode && $past(!sleep_mode) |-> !req_ack)
        else $error("request taken in continuous mode");
    ack_when_down_a:
        assert property (sleep_mode && measure_request_cmd && powered_down
            && out_select == 3'h1 |=> req_ack)
        else $error("sleep request not taken");
endmodule : msf_core_sva

bind msf_core msf_core_sva msf_core_sva_inst (.*);

// File: bench/msf_core_tb.sv
// Self-checking bench of the measurement sequencing core.
// Assumes the host model drives the fetch side; power-down counts shortened.
`timescale 1ns/10ps
module msf_core_tb;
    // ****************************************************************
    // Stimulus and checks
    // ****************************************************************
    localparam int PD1 = 20, PD2 = 40, PD3 = 60, CAL = 8;
    logic        clk_sys = 1'b0, rst_b = 1'b0, sleep_mode = 1'b1;
    logic        command_mode = 1'b0, cfg_load_done = 1'b0;
    logic        cfg_parity_err = 1'b0, alarm_lo_hit = 1'b0;
    logic        alarm_hi_hit = 1'b0;
    logic [1:0]  update_rate = 2'h0;
    logic [2:0]  out_select = 3'h1;
    logic [3:0]  err_v = 4'h0;
    logic [13:0] cap_value = 14'h0, temp_value = 14'h0;
    wire logic   single_bit_fixed, ram_parity_err, double_bit_detected;
    wire logic   math_overflow, spi_mode, measure_request_cmd;
    wire logic   result_read_cmd, fetch_done, pin_ready_ack;
    logic [31:0] fetch_data, w, w2;
    logic        fetch_valid, ready_pin, alarm_lo, alarm_hi, req_ack;
    logic        cap_density_out, temp_density_out, powered_down;
    logic        conv_temp, conv_cap, diag_active, g;
    int          num_errors = 0, cmp_count = 0, cyc = 0, n, pd, e;

    assign {math_overflow, double_bit_detected, ram_parity_err,
            single_bit_fixed} = err_v;
    assign spi_mode = (out_select == msf_pkg::OSEL_SPI);
    always #5 clk_sys = ~clk_sys;

    msf_core #(.PD1(PD1), .PD2(PD2), .PD3(PD3), .CONV(16), .CALC(CAL))
        msf_core_inst (.*);
    msf_host_model msf_host_model_inst (.*);

    task automatic finish_test();
        $display("Compared %0d values, %0d wrong", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] exp_word(input logic [1:0] s,
        input logic d, input logic [13:0] c, input logic [13:0] t);
        return {s, d ? msf_pkg::DIAG_CODE : c, d ? msf_pkg::DIAG_CODE : t,
                2'h0};
    endfunction : exp_word

    // Waits on cap, temp, down, up, cap low for sel 0 to 4
    task automatic wait_on(input int sel, output logic seen);
        logic [4:0] v;
        n = 0;
        seen = 1'b0;
        while (!seen && n < 300)
        begin
            @(posedge clk_sys);
            n++;
            v = {~conv_cap, ~powered_down, powered_down, conv_temp, conv_cap};
            seen = (v[sel] === 1'b1);
        end
    endtask : wait_on

    task automatic do_reset(input logic slp, input logic [2:0] sel,
                            input logic [1:0] rate, input logic cerr);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        sleep_mode <= slp;
        out_select <= sel;
        update_rate <= rate;
        repeat (5) @(posedge clk_sys);
        chk({ready_pin, fetch_valid, req_ack, powered_down}, 32'h0);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        cfg_load_done <= 1'b1;
        cfg_parity_err <= cerr;
        @(posedge clk_sys);
        cfg_load_done <= 1'b0;
        cfg_parity_err <= 1'b0;
    endtask : do_reset

    // Kind 0 to 3 pulses one error input during conversion, 4 none
    task automatic run_sleep(input int kind, input logic perm,
                             input logic early);
        logic [13:0] c, t;
        logic        d, lo;
        c = 14'($urandom) & 14'h1fff;
        t = 14'($urandom) & 14'h1fff;
        lo = 1'($urandom);
        d = perm || (kind > 0 && kind < 4);
        cap_value <= c;
        temp_value <= t;
        alarm_lo_hit <= lo;
        alarm_hi_hit <= ~lo;
        msf_host_model_inst.measure();
        if (early)
        begin
            msf_host_model_inst.fetch(w, g);
            chk(w[31:30], msf_pkg::STAT_STALE);
        end
        wait_on(0, g);
        err_v <= (kind < 4) ? 4'(1 << kind) : 4'h0;
        @(posedge clk_sys);
        err_v <= 4'h0;
        msf_host_model_inst.wait_ready(g);
        chk(g, 1'b1);
        chk({alarm_lo, alarm_hi}, {lo, ~lo});
        chk(diag_active, d);
        msf_host_model_inst.fetch(w, g);
        chk(w, exp_word(msf_pkg::STAT_VALID, d, c, t));
        msf_host_model_inst.fetch(w, g);
        chk(w, exp_word(msf_pkg::STAT_STALE, d, c, t));
        repeat (30) @(posedge clk_sys);
        chk(powered_down, 1'b1);
    endtask : run_sleep

    initial
    begin
        void'($urandom(32'h700c));
        do_reset(1'b1, 3'h1, 2'h0, 1'b0);
        msf_host_model_inst.fetch(w, g);
        chk(w[31:30], msf_pkg::STAT_STALE);
        for (int k = 0; k < 8; k++)
            run_sleep(k % 5, 1'b0, k == 5);
        msf_host_model_inst.measure();
        wait_on(0, g);
        msf_host_model_inst.measure();
        msf_host_model_inst.wait_ready(g);
        wait_on(1, g);
        chk(g, 1'b1);
        wait_on(2, g);
        msf_host_model_inst.fetch(w, g);
        command_mode <= 1'b1;
        repeat (4) @(posedge clk_sys);
        msf_host_model_inst.fetch(w, g);
        chk(w[31:30], msf_pkg::STAT_CMD);
        command_mode <= 1'b0;
        repeat (9) msf_host_model_inst.pulse_read();
        for (int k = 0; k < 9; k++)
        begin
            msf_host_model_inst.pop(w, g);
            chk(g, k < 8);
        end
        do_reset(1'b1, msf_pkg::OSEL_SPI, 2'h0, 1'b0);
        msf_host_model_inst.measure();
        msf_host_model_inst.wait_ready(g);
        msf_host_model_inst.measure();
        msf_host_model_inst.wait_ready(g);
        chk(g, 1'b1);
        for (int r = 0; r < 4; r++)
        begin
            do_reset(1'b0, 3'h1, 2'(r), 1'b0);
            if (r == 0)
            begin
                wait_on(1, g);
                w[1:0] = 2'b10;
                pd = 0;
                do
                begin
                    @(posedge clk_sys);
                    pd += (conv_cap === 1'b1 && !w[0]);
                    g = (conv_temp === 1'b1 && !w[1]);
                    w[1:0] = {conv_temp, conv_cap};
                end while (!g && cyc < 19000);
                chk(pd, msf_pkg::TEMP_EVERY);
            end
            wait_on(0, g);
            wait_on(2, g);
            pd = g;
            while (powered_down === 1'b1 && pd < 200)
            begin
                @(posedge clk_sys);
                pd += powered_down;
            end
            e = (r == 0) ? 0 : (r == 1) ? PD1 : (r == 2) ? PD2 : PD3;
            chk(pd >= e && pd <= e + 1, 1'b1);
            if (r == 3)
            begin
                wait_on(2, g);
                msf_host_model_inst.fetch(w, g);
                msf_host_model_inst.fetch(w2, g);
                chk(w[31:30], msf_pkg::STAT_VALID);
                chk(w2, {msf_pkg::STAT_STALE, w[29:0]});
            end
        end
        do_reset(1'b0, msf_pkg::OSEL_PDM_CT, 2'h0, 1'b0);
        wait_on(0, g);
        err_v <= 4'h8;
        @(posedge clk_sys);
        err_v <= 4'h0;
        wait_on(4, g);
        repeat (CAL + 6) @(posedge clk_sys);
        chk({cap_density_out, temp_density_out}, 2'b11);
        do_reset(1'b1, 3'h1, 2'h0, 1'b1);
        repeat (2) run_sleep(4, 1'b1, 1'b0);
        finish_test();
    end
endmodule : msf_core_tb

// File: bench/msf_host_model.sv
// Host controller model on the fetch side: requests, fetches, ready ack.
// Assumes the bench calls its tasks; drives change just after clk_sys edges.
`timescale 1ns/10ps
module msf_host_model
(
    input  wire logic        clk_sys,
    input  wire logic        spi_mode,
    input  wire logic        ready_pin,
    input  wire logic        fetch_valid,
    input  wire logic [31:0] fetch_data,
    output logic             measure_request_cmd,
    output logic             result_read_cmd,
    output logic             fetch_done,
    output logic             pin_ready_ack
);
    // ****************************************************************
    // Host requests
    // ****************************************************************
    logic owed = 1'b0;  // Result requested and not fetched yet

    initial
    begin
        measure_request_cmd = 1'b0;
        result_read_cmd = 1'b0;
        fetch_done = 1'b0;
        pin_ready_ack = 1'b0;
    end

    task automatic pulse_read();
        @(posedge clk_sys);
        result_read_cmd <= 1'b1;
        @(posedge clk_sys);
        result_read_cmd <= 1'b0;
    endtask : pulse_read

    // Random stall of at least one edge keeps back-to-back pops legal
    task automatic pop(output logic [31:0] w, output logic got);
        int n;
        n = 0;
        got = 1'b0;
        repeat (1 + $urandom_range(2)) @(posedge clk_sys);
        fetch_done <= 1'b1;
        while (!got && n < 50)
        begin
            @(posedge clk_sys);
            n++;
            got = (fetch_valid === 1'b1);
        end
        w = fetch_data;
        fetch_done <= 1'b0;
        owed = 1'b0;
    endtask : pop

    task automatic fetch(output logic [31:0] w, output logic got);
        pulse_read();
        pop(w, got);
    endtask : fetch

    task automatic measure();
        logic [31:0] w;
        logic        got;
        if (spi_mode && owed)
            fetch(w, got);
        @(posedge clk_sys);
        measure_request_cmd <= 1'b1;
        @(posedge clk_sys);
        measure_request_cmd <= 1'b0;
        owed = 1'b1;
    endtask : measure

    // Serial polling would add noise, so the host waits on the pin
    task automatic wait_ready(output logic seen);
        int n;
        n = 0;
        seen = 1'b0;
        while (!seen && n < 400)
        begin
            @(posedge clk_sys);
            n++;
            seen = (ready_pin === 1'b1);
        end
        pin_ready_ack <= seen;
        repeat (2) @(posedge clk_sys);
        pin_ready_ack <= 1'b0;
    endtask : wait_ready
endmodule : msf_host_model

// File: src/msf_core.sv
// Measurement sequencing, result status and diagnostic reporting.
// Assumes serial decode, conversion and DSP live outside and signal here
// by same-clock pulses; only the ready pin path is treated as a pin.
`timescale 1ns/10ps
module msf_core
#(
    parameter int PD1 = msf_pkg::PD_CYC_01,
    parameter int PD2 = msf_pkg::PD_CYC_10,
    parameter int PD3 = msf_pkg::PD_CYC_11,
    parameter int CONV = msf_pkg::CONV_CYC,
    parameter int CALC = msf_pkg::CALC_CYC
)
(
    input  wire logic                        clk_sys,
    input  wire logic                        rst_b,
    input  wire logic                        sleep_mode,
    input  wire logic [1:0]                  update_rate,
    input  wire logic [2:0]                  out_select,
    input  wire logic                        command_mode,
    input  wire logic                        cfg_load_done,
    input  wire logic                        cfg_parity_err,
    input  wire logic                        ram_parity_err,
    input  wire logic                        double_bit_detected,
    input  wire logic                        single_bit_fixed,
    input  wire logic                        math_overflow,
    input  wire logic [msf_pkg::RES_W-1:0]   cap_value,
    input  wire logic [msf_pkg::RES_W-1:0]   temp_value,
    input  wire logic                        alarm_lo_hit,
    input  wire logic                        alarm_hi_hit,
    input  wire logic                        measure_request_cmd,
    input  wire logic                        result_read_cmd,
    input  wire logic                        fetch_done,
    input  wire logic                        pin_ready_ack,
    output logic [31:0]                      fetch_data,
    output logic                             fetch_valid,
    output logic                             ready_pin,
    output logic                             alarm_lo,
    output logic                             alarm_hi,
    output logic                             cap_density_out,
    output logic                             temp_density_out,
    output logic                             powered_down,
    output logic                             conv_temp,
    output logic                             conv_cap,
    output logic                             diag_active,
    output logic                             req_ack
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed
    {
        msf_pkg::msf_state_e         fsm;
        logic [31:0]                 tmr;
        logic [2:0]                  cap_cnt;
        logic                        do_temp;
        logic                        perm_diag;
        logic                        tran_diag;
        logic                        rep_diag;
        logic                        fetched;
        logic [msf_pkg::RES_W-1:0]   cap_reg;
        logic [msf_pkg::RES_W-1:0]   temp_reg;
        logic                        pend_req;
        logic                        ready;
        logic                        alo;
        logic                        ahi;
        logic                        pdc;
        logic                        pdt;
        logic [31:0]                 acc_c;
        logic [31:0]                 acc_t;
        logic                        req_ack;
    } msf_core_s;

    msf_core_s st_r;
    msf_core_s st_nxt;
    logic      ack_sync;
    logic      push_ok;
    logic      pdm_sel;
    logic      ser_sel;

    function automatic logic [31:0] pd_len(input logic [1:0] rate);
        case (rate)
            msf_pkg::RATE_0MS:  pd_len = 32'h0;
            msf_pkg::RATE_5MS:  pd_len = 32'(PD1);
            msf_pkg::RATE_25MS: pd_len = 32'(PD2);
            default:            pd_len = 32'(PD3);
        endcase
    endfunction : pd_len

    function automatic logic [31:0] pack(input logic [1:0] stat,
                                         input logic       diag,
                                         input logic [13:0] c,
                                         input logic [13:0] t);
        logic [13:0] cv;
        logic [13:0] tv;
        cv   = diag ? msf_pkg::DIAG_CODE : c;
        tv   = diag ? msf_pkg::DIAG_CODE : t;
        pack = {stat, cv, tv, 2'h0};
    endfunction : pack

    assign pdm_sel = (out_select == msf_pkg::OSEL_CAP_DENSITY_OUT) ||
                     (out_select == msf_pkg::OSEL_PDM_CT);
    assign ser_sel = (out_select == 3'(msf_pkg::OSEL_I2C)) ||
                     (out_select == msf_pkg::OSEL_SPI);

    msf_pipe u_ack
    (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .din     (pin_ready_ack),
        .dout    (ack_sync)
    );

    msf_fifo
    #(
        .W (32),
        .D (msf_pkg::FIFO_DEPTH)
    )
    u_fifo
    (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .in_valid  (result_read_cmd),
        .in_ready  (push_ok),
        .in_data   (pack(command_mode ? msf_pkg::STAT_CMD :
                         (st_r.fetched ? msf_pkg::STAT_STALE
                                       : msf_pkg::STAT_VALID),
                         st_r.rep_diag, st_r.cap_reg, st_r.temp_reg)),
        .out_valid (fetch_valid),
        .out_ready (fetch_done),
        .out_data  (fetch_data)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.req_ack = 1'b0;
        if (st_r.tmr != 32'h0)
            st_nxt.tmr = st_r.tmr - 32'h1;
        if (measure_request_cmd && sleep_mode && ser_sel)
        begin
            st_nxt.pend_req = 1'b1;
            st_nxt.req_ack  = 1'b1;
        end
        if (result_read_cmd && push_ok)
            st_nxt.fetched = 1'b1;
        if (ack_sync || result_read_cmd)
            st_nxt.ready = 1'b0;
        if (cfg_parity_err)
            st_nxt.perm_diag = 1'b1;
        if (ram_parity_err || double_bit_detected || math_overflow)
            st_nxt.tran_diag = 1'b1;

        case (st_r.fsm)
            msf_pkg::ST_BOOT:
                if (cfg_load_done)
                begin
                    st_nxt.fsm     = sleep_mode ? msf_pkg::ST_DOWN
                                                : msf_pkg::ST_TEMP;
                    st_nxt.tmr     = sleep_mode ? 32'h0 : 32'(CONV);
                    st_nxt.fetched = 1'b1;
                    st_nxt.do_temp = 1'b1;
                end
            msf_pkg::ST_DOWN:
                if (sleep_mode ? st_r.pend_req : (st_r.tmr == 32'h0))
                begin
                    // A request or error in the wake cycle is kept
                    st_nxt.pend_req  = st_nxt.req_ack;
                    st_nxt.tran_diag = ram_parity_err ||
                                       double_bit_detected || math_overflow;
                    st_nxt.do_temp   = sleep_mode ||
                                       (st_r.cap_cnt == 3'(msf_pkg::TEMP_EVERY));
                    st_nxt.fsm       = (sleep_mode || st_nxt.do_temp) ?
                                       msf_pkg::ST_TEMP : msf_pkg::ST_CAP;
                    st_nxt.tmr       = 32'(CONV);
                end
            msf_pkg::ST_TEMP:
                if (st_r.tmr == 32'h0)
                begin
                    st_nxt.fsm     = msf_pkg::ST_CAP;
                    st_nxt.tmr     = 32'(CONV);
                    st_nxt.cap_cnt = 3'h0;
                end
            msf_pkg::ST_CAP:
                if (st_r.tmr == 32'h0)
                begin
                    st_nxt.fsm     = msf_pkg::ST_CALC;
                    st_nxt.tmr     = 32'(CALC);
                    st_nxt.cap_cnt = st_r.cap_cnt + 3'h1;
                end
            msf_pkg::ST_CALC:
                if (st_r.tmr == 32'h0)
                    st_nxt.fsm = msf_pkg::ST_UPD;
            msf_pkg::ST_UPD:
            begin
                st_nxt.cap_reg  = cap_value;
                if (st_r.do_temp || sleep_mode)
                    st_nxt.temp_reg = temp_value;
                st_nxt.rep_diag = st_r.perm_diag || st_r.tran_diag
                                  || cfg_parity_err;
                st_nxt.alo      = alarm_lo_hit;
                st_nxt.ahi      = alarm_hi_hit;
                st_nxt.fetched  = 1'b0;
                st_nxt.ready    = 1'b1;
                st_nxt.fsm      = msf_pkg::ST_DOWN;
                st_nxt.tmr      = pd_len(update_rate);
            end
            default:
                st_nxt.fsm = msf_pkg::ST_BOOT;
        endcase

        // Density modulators: first-order accumulators, railed high on
        // diagnostic; disabled in sleep since nothing else could request.
        st_nxt.acc_c = {18'h0, st_r.acc_c[13:0]} + {18'h0, st_r.cap_reg};
        st_nxt.acc_t = {18'h0, st_r.acc_t[13:0]} + {18'h0, st_r.temp_reg};
        if (!pdm_sel || sleep_mode)
        begin
            st_nxt.pdc = 1'b0;
            st_nxt.pdt = 1'b0;
        end
        else if (st_r.rep_diag)
        begin
            st_nxt.pdc = 1'b1;
            st_nxt.pdt = 1'b1;
        end
        else
        begin
            st_nxt.pdc = st_r.acc_c[14];
            st_nxt.pdt = st_r.acc_t[14];
        end
        st_nxt.acc_c[31:15] = 17'h0;
        st_nxt.acc_t[31:15] = 17'h0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            st_r     <= '0;
            st_r.fsm <= msf_pkg::ST_BOOT;
        end
        else
            st_r <= st_nxt;
    end

    // ****************************************************************
    // Outputs, from flip-flops; state flags decoded from st_r.fsm
    // ****************************************************************
    assign ready_pin        = st_r.ready;
    assign alarm_lo         = st_r.alo;
    assign alarm_hi         = st_r.ahi;
    assign cap_density_out  = st_r.pdc;
    assign temp_density_out = st_r.pdt;
    assign powered_down     = (st_r.fsm == msf_pkg::ST_DOWN);
    assign conv_temp        = (st_r.fsm == msf_pkg::ST_TEMP);
    assign conv_cap         = (st_r.fsm == msf_pkg::ST_CAP);
    assign diag_active      = st_r.rep_diag;
    assign req_ack          = st_r.req_ack;
endmodule : msf_core

// File: src/msf_fifo.sv
// Result FIFO between the output register update and the serial fetch side.
// Assumes one clock; read data comes from a register.
`timescale 1ns/10ps
module msf_fifo
#(
    parameter int W = 32,
    parameter int D = 8
)
(
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed
    {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          ov;
        logic [W-1:0]  od;
    } msf_fifo_s;

    msf_fifo_s          st_r;
    msf_fifo_s          st_nxt;
    logic [W-1:0]       mem [D];
    logic               push;
    logic               pop;

    // The output register holds a word too, so it counts toward the depth
    assign in_ready  = ((st_r.cnt + (AW+1)'(st_r.ov)) != (AW+1)'(D));
    assign push      = in_valid && in_ready;
    assign pop       = (!st_r.ov || out_ready) && (st_r.cnt != '0);
    assign out_valid = st_r.ov;
    assign out_data  = st_r.od;

    always_comb
    begin
        st_nxt = st_r;
        if (push)
            st_nxt.wp = (st_r.wp == AW'(D-1)) ? '0 : st_r.wp + 1'b1;
        if (pop)
        begin
            st_nxt.rp = (st_r.rp == AW'(D-1)) ? '0 : st_r.rp + 1'b1;
            st_nxt.od = mem[st_r.rp];
            st_nxt.ov = 1'b1;
        end
        else if (out_ready)
            st_nxt.ov = 1'b0;
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[st_r.wp] <= in_data;
        if (!rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
endmodule : msf_fifo

// File: src/msf_pipe.sv
// Two-flop synchroniser for a pin-level input.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/10ps
module msf_pipe
(
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed
    {
        logic meta;
        logic sync;
    } msf_pipe_s;

    msf_pipe_s st_r;
    msf_pipe_s st_nxt;

    always_comb
    begin
        st_nxt.meta = din;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign dout = st_r.sync;
endmodule : msf_pipe

// File: src/msf_pkg.sv
// Shared constants and types of the measurement sequencing and fetch block.
// Assumes a 100 MHz system clock; long waits are shortened via parameters.
package msf_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          CLK_MHZ       = 100;
    localparam int          PD_MS_01      = 5;
    localparam int          PD_MS_10      = 25;
    localparam int          PD_MS_11      = 125;
    localparam int          MS_CYC        = CLK_MHZ * 1000;
    localparam int          PD_CYC_01     = PD_MS_01 * MS_CYC;
    localparam int          PD_CYC_10     = PD_MS_10 * MS_CYC;
    localparam int          PD_CYC_11     = PD_MS_11 * MS_CYC;
    localparam int          CONV_CYC      = 64;
    localparam int          CALC_CYC      = 16;
    localparam int          TEMP_EVERY    = 6;

    // ****************************************************************
    // Encodings and field positions
    // ****************************************************************
    localparam logic [1:0]  STAT_VALID    = 2'h0;
    localparam logic [1:0]  STAT_STALE    = 2'h1;
    localparam logic [1:0]  STAT_CMD      = 2'h2;
    localparam logic [13:0] DIAG_CODE     = 14'h3fff;
    localparam int          STAT_POS      = 14;
    localparam logic [1:0]  RATE_0MS      = 2'h0;
    localparam logic [1:0]  RATE_5MS      = 2'h1;
    localparam logic [1:0]  RATE_25MS     = 2'h2;
    localparam logic [2:0]  OSEL_I2C      = 3'h1;
    localparam logic [2:0]  OSEL_SPI      = 3'h3;
    localparam logic [2:0]  OSEL_CAP_DENSITY_OUT    = 3'h4;
    localparam logic [2:0]  OSEL_PDM_CT   = 3'h6;
    localparam int          RES_W         = 14;
    localparam int          FIFO_DEPTH    = 8;

    typedef enum logic [2:0]
    {
        ST_BOOT  = 3'b000,
        ST_DOWN  = 3'b001,
        ST_TEMP  = 3'b010,
        ST_CAP   = 3'b011,
        ST_CALC  = 3'b100,
        ST_UPD   = 3'b101
    } msf_state_e;

endpackage : msf_pkg
